/* File: hw/acs_core.sv */
// converter selection buffering, start timing, amplified starts and sleep starts
`timescale 1ns/10ps
module acs_core
   import acs_pkg::*;
#(
   parameter int PRESC_MAX_LOG = 7
)
(
   input wire logic clk_sys, // 40 MHz system clock
   input wire logic rst_b, // asynchronous reset, active low
   input wire logic [7:0] reg_addr, // register byte address
   input wire logic [7:0] reg_wdata, // register write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [15:0] reg_rdata, // read data, cycle after read strobe
   input wire logic amp_trigger, // amplifier trigger event pulse
   input wire logic auto_trigger_evt, // selected auto trigger source level
   input wire logic cpu_halt_idle, // cpu halted in idle or noise sleep
   input wire logic [RESULT_W-1:0] core_result, // raw code from conversion core
   input wire logic core_overrange, // single-ended input above reference
   input wire logic core_single_ended, // active channel is single-ended
   output logic [CHAN_W-1:0] active_channel, // channel to analog multiplexer
   output logic [REF_W-1:0] active_reference, // reference selection to core
   output logic amp_input_short, // tie amplifier inputs together
   output logic conv_sample, // pulse: conversion starts
   output logic conv_running, // conversion in progress
   output logic conv_enable, // converter powered
   output logic irq // level interrupt
);
   logic [7:0] input_select_register;
   logic converter_enable;
   logic start_conversion_bit;
   logic auto_trigger_enable;
   logic conversion_done_flag;
   logic done_irq_enable;
   logic [PRESC_W-1:0] presc_sel;
   logic amplified_start_request;
   logic amplifier_input_short;
   logic free_run;
   logic [RESULT_W-1:0] result;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_mask;
   logic [IRQ_W-1:0] irq_event;
   logic [PRESC_MAX_LOG-1:0] presc_cnt;
   logic [PRESC_MAX_LOG-1:0] presc_mask;
   logic conv_tick;
   logic first_conv;
   logic amp_conv;
   logic [4:0] cyc_cnt;
   logic [4:0] cyc_last;
   logic trig_prev;
   logic halt_prev;
   logic wr_start;
   logic hw_start;
   logic auto_start;
   logic sleep_start;
   logic finishing;
   logic done_now;
   acs_state_t state;
   acs_state_t next_state;

   wire wr_sel = reg_wr && reg_addr == ADDR_SELECT;
   wire wr_a = reg_wr && reg_addr == ADDR_CONTROL_A;
   wire wr_b = reg_wr && reg_addr == ADDR_CONTROL_B;

   // converter clock: one-cycle enable from a prescaler held while disabled
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         presc_cnt <= '0;
      else if (!converter_enable || auto_start)
         presc_cnt <= '0;
      else
         presc_cnt <= presc_cnt + 1'b1;
   end
   always_comb
   begin
      // a zero mask gives a tick on every clock
      presc_mask = PRESC_MAX_LOG'((32'd1 << presc_sel) - 32'd1);
      conv_tick = converter_enable && ((presc_cnt & presc_mask) == presc_mask);
   end

   assign wr_start = wr_a && reg_wdata[BIT_START] && reg_wdata[BIT_ENABLE];
   assign hw_start = amplified_start_request && amp_trigger;
   assign auto_start = auto_trigger_enable && auto_trigger_evt && !trig_prev
      && !conversion_done_flag && state == ST_IDLE;
   // halting cpu starts a conversion through the noise canceler, a single one unless free_run is set
   assign sleep_start = cpu_halt_idle && !halt_prev && converter_enable
      && !auto_trigger_enable && state == ST_IDLE;
   assign cyc_last = first_conv ? 5'(CONV_FIRST_CYC - 1) : 5'(CONV_NORMAL_CYC - 1);
   assign finishing = state == ST_CONVERT && cyc_cnt == cyc_last;
   assign done_now = finishing && conv_tick;

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         trig_prev <= 1'b0;
         halt_prev <= 1'b0;
      end
      else
      begin
         trig_prev <= auto_trigger_evt;
         halt_prev <= cpu_halt_idle;
      end
   end

   // sequencing state machine
   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_IDLE:
            if (start_conversion_bit || auto_start)
               next_state = ST_WAIT_EDGE;
         ST_WAIT_EDGE:
            if (conv_tick)
               next_state = ST_CONVERT;
         ST_CONVERT:
            if (done_now)
               next_state = (free_run && !amp_conv) ? ST_CONVERT : ST_IDLE;
      endcase
      if (!converter_enable)
         next_state = ST_IDLE;
   end
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         cyc_cnt <= '0;
      else if (state != ST_CONVERT || done_now)
         cyc_cnt <= '0;
      else if (conv_tick)
         cyc_cnt <= cyc_cnt + 5'd1;
   end

   // first conversion after enabling takes the long count
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         first_conv <= 1'b1;
      else if (!converter_enable)
         first_conv <= 1'b1;
      else if (done_now)
         first_conv <= 1'b0;
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         amp_conv <= 1'b0;
      else if (hw_start)
         amp_conv <= 1'b1;
      else if (done_now)
         amp_conv <= 1'b0;
   end

   // selection buffer: software writes any time
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         input_select_register <= SELECT_RST;
      else if (wr_sel)
         input_select_register <= reg_wdata;
   end
   // active copy follows buffer except while locked by a conversion
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         active_channel <= '0;
         active_reference <= '0;
      end
      else if (state != ST_CONVERT || finishing)
      begin
         active_channel <= input_select_register[CHAN_LSB +: CHAN_W];
         active_reference <= input_select_register[REF_LSB +: REF_W];
      end
   end

   // control a; start may be set by software, amplifier or sleep
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         converter_enable <= CONTROL_A_RST[BIT_ENABLE];
         auto_trigger_enable <= CONTROL_A_RST[BIT_AUTO];
         done_irq_enable <= CONTROL_A_RST[BIT_DONE_IE];
         presc_sel <= CONTROL_A_RST[PRESC_LSB +: PRESC_W];
      end
      else if (wr_a)
      begin
         converter_enable <= reg_wdata[BIT_ENABLE];
         auto_trigger_enable <= reg_wdata[BIT_AUTO];
         done_irq_enable <= reg_wdata[BIT_DONE_IE];
         presc_sel <= reg_wdata[PRESC_LSB +: PRESC_W];
      end
   end
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         start_conversion_bit <= CONTROL_A_RST[BIT_START];
      else if (wr_start || hw_start || sleep_start)
         start_conversion_bit <= 1'b1;
      else if (!converter_enable)
         start_conversion_bit <= 1'b0;
      else if (done_now && (!free_run || amp_conv))
         start_conversion_bit <= 1'b0;
   end
   // done flag: completion wins over a write-one clear in the same cycle
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         conversion_done_flag <= 1'b0;
      else if (done_now)
         conversion_done_flag <= 1'b1;
      else if (wr_a && reg_wdata[BIT_DONE])
         conversion_done_flag <= 1'b0;
   end

   // control b
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         amplifier_input_short <= CONTROL_B_RST[BIT_AMP_SHORT];
         free_run <= CONTROL_B_RST[BIT_FREE_RUN];
      end
      else if (wr_b)
      begin
         amplifier_input_short <= reg_wdata[BIT_AMP_SHORT];
         free_run <= reg_wdata[BIT_FREE_RUN];
      end
   end
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         amplified_start_request <= CONTROL_B_RST[BIT_AMP_REQ];
      else if (hw_start)
         amplified_start_request <= 1'b0;
      else if (wr_b)
         amplified_start_request <= reg_wdata[BIT_AMP_REQ];
   end

   // result capture; overrange single-ended input clamps to full scale
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         result <= '0;
      else if (done_now)
         result <= (core_single_ended && core_overrange) ? FULL_SCALE : core_result;
   end

   // interrupts: sticky status, write one to clear, set wins
   assign irq_event[IRQ_DONE] = done_now && done_irq_enable;
   assign irq_event[IRQ_AMP_START] = hw_start;
   assign irq_event[IRQ_SLEEP_START] = sleep_start;
   genvar gi;
   generate
      for (gi = 0; gi < IRQ_W; gi++)
      begin : g_irq
         always_ff @(posedge clk_sys or negedge rst_b)
         begin
            if (!rst_b)
               irq_status[gi] <= 1'b0;
            else if (irq_event[gi])
               irq_status[gi] <= 1'b1;
            else if (reg_wr && reg_addr == ADDR_IRQ_STATUS && reg_wdata[gi])
               irq_status[gi] <= 1'b0;
         end
      end
   endgenerate
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         irq_mask <= '0;
      else if (reg_wr && reg_addr == ADDR_IRQ_MASK)
         irq_mask <= reg_wdata[IRQ_W-1:0];
   end

   // registered outputs
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         irq <= 1'b0;
         conv_sample <= 1'b0;
         conv_running <= 1'b0;
         conv_enable <= 1'b0;
         amp_input_short <= 1'b0;
      end
      else
      begin
         irq <= |(irq_status & irq_mask);
         conv_sample <= (state == ST_WAIT_EDGE && conv_tick) || (done_now && free_run && !amp_conv);
         conv_running <= next_state == ST_CONVERT;
         conv_enable <= converter_enable;
         amp_input_short <= amplifier_input_short;
      end
   end

   // read port; unmapped addresses read zero
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         reg_rdata <= '0;
      else if (reg_rd)
      begin
         unique case (reg_addr)
            ADDR_SELECT: reg_rdata <= {8'h00, input_select_register};
            ADDR_CONTROL_A: reg_rdata <= {8'h00, converter_enable, start_conversion_bit,
               auto_trigger_enable, conversion_done_flag, done_irq_enable, presc_sel};
            ADDR_CONTROL_B: reg_rdata <= {8'h00, amplified_start_request,
               amplifier_input_short, 5'h00, free_run};
            ADDR_RESULT: reg_rdata <= {6'h00, result};
            ADDR_IRQ_STATUS: reg_rdata <= {13'h0000, irq_status};
            ADDR_IRQ_MASK: reg_rdata <= {13'h0000, irq_mask};
            ADDR_ACTIVE_SEL: reg_rdata <= {8'h00, active_reference, 2'h0, active_channel};
            default: reg_rdata <= '0;
         endcase
      end
      else
         reg_rdata <= '0;
   end
endmodule

/* File: pkg/acs_pkg.sv */
// constants shared by the converter selection and sequencing block
package acs_pkg;
   // register word offsets (byte addresses)
   localparam logic [7:0] ADDR_SELECT = 8'h00;
   localparam logic [7:0] ADDR_CONTROL_A = 8'h04;
   localparam logic [7:0] ADDR_CONTROL_B = 8'h08;
   localparam logic [7:0] ADDR_RESULT = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
   localparam logic [7:0] ADDR_ACTIVE_SEL = 8'h18;
   // input_select_register fields
   localparam int CHAN_LSB = 0;
   localparam int CHAN_W = 4;
   localparam int REF_LSB = 6;
   localparam int REF_W = 2;
   // converter_control_a fields
   localparam int BIT_ENABLE = 7;
   localparam int BIT_START = 6;
   localparam int BIT_AUTO = 5;
   localparam int BIT_DONE = 4;
   localparam int BIT_DONE_IE = 3;
   localparam int PRESC_LSB = 0;
   localparam int PRESC_W = 3;
   // converter_control_b fields
   localparam int BIT_AMP_REQ = 7;
   localparam int BIT_AMP_SHORT = 6;
   localparam int BIT_FREE_RUN = 0;
   // interrupt status / mask bits
   localparam int IRQ_DONE = 0;
   localparam int IRQ_AMP_START = 1;
   localparam int IRQ_SLEEP_START = 2;
   localparam int IRQ_W = 3;
   // timing, in converter clock cycles; result width and full-scale code
   localparam int CONV_NORMAL_CYC = 13;
   localparam int CONV_FIRST_CYC = 25;
   localparam int RESULT_W = 10;
   localparam logic [RESULT_W-1:0] FULL_SCALE = 10'h3ff;
   // reset values
   localparam logic [7:0] SELECT_RST = 8'h00;
   localparam logic [7:0] CONTROL_A_RST = 8'h00;
   localparam logic [7:0] CONTROL_B_RST = 8'h00;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_WAIT_EDGE = 3'b010,
      ST_CONVERT = 3'b100
   } acs_state_t;
endpackage

/* File: testbench/acs_core_chk.sv */
// port-level assertions for the converter selection and sequencing block
`timescale 1ns/10ps
module acs_core_chk
   import acs_pkg::*;
(
   input wire logic clk_sys, // system clock
   input wire logic rst_b, // reset, active low
   input wire logic [7:0] reg_addr, // register address
   input wire logic [7:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   input wire logic [15:0] reg_rdata, // read data
   input wire logic amp_trigger, // amplifier trigger
   input wire logic auto_trigger_evt, // auto trigger level
   input wire logic cpu_halt_idle, // cpu halted
   input wire logic [RESULT_W-1:0] core_result, // raw code
   input wire logic core_overrange, // above reference
   input wire logic core_single_ended, // single-ended channel
   input wire logic [CHAN_W-1:0] active_channel, // active channel
   input wire logic [REF_W-1:0] active_reference, // active reference
   input wire logic amp_input_short, // amplifier inputs tied
   input wire logic conv_sample, // start pulse
   input wire logic conv_running, // conversion busy
   input wire logic conv_enable, // converter on
   input wire logic irq // interrupt
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   sequence s_conv_start;
      $rose(conv_running);
   endsequence
   sequence s_sel_write;
      reg_wr && reg_addr == ADDR_SELECT && !conv_running;
   endsequence
   // two idle cycles give the buffer and the copy one edge each
   property p_sel_follow;
      logic [5:0] v;
      (s_sel_write, v = {reg_wdata[7:6], reg_wdata[3:0]}) ##1 (!conv_running && !reg_wr)
         ##1 !conv_running |-> {active_reference, active_channel} == v;
   endproperty
   property p_short_follow;
      logic v;
      (reg_wr && reg_addr == ADDR_CONTROL_B, v = reg_wdata[BIT_AMP_SHORT])
         |=> ##1 amp_input_short == v;
   endproperty
   a_sel_follow: assert property (p_sel_follow) else $error("selection not copied");
   a_sel_locked: assert property (s_conv_start |=> $stable({active_reference, active_channel})[*8])
      else $error("selection moved in conversion");
   a_run_length: assert property (s_conv_start |-> conv_running[*8])
      else $error("conversion too short");
   a_start_edge: assert property (conv_sample |-> conv_enable ##[0:1] conv_running)
      else $error("start without run");
   a_short_follow: assert property (p_short_follow) else $error("short bit wrong");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside slot");
   a_unmapped_rd: assert property (reg_rd && reg_addr == 8'hfc |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_enable_hold: assert property (conv_enable && !(reg_wr && reg_addr == ADDR_CONTROL_A)
      && !$past(reg_wr && reg_addr == ADDR_CONTROL_A) |=> conv_enable)
      else $error("converter turned off by itself");
endmodule
bind acs_core acs_core_chk u_acs_core_chk (.clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .amp_trigger, .auto_trigger_evt, .cpu_halt_idle, .core_result,
   .core_overrange, .core_single_ended, .active_channel, .active_reference, .amp_input_short,
   .conv_sample, .conv_running, .conv_enable, .irq);

/* File: testbench/acs_far_model.sv */
// behavioural model of the multiplexer and conversion core
`timescale 1ns/10ps
module acs_far_model
   import acs_pkg::*;
(
   input wire logic clk_sys, // system clock
   input wire logic rst_b, // reset, active low
   input wire logic [CHAN_W-1:0] active_channel, // selected channel
   input wire logic [REF_W-1:0] active_reference, // selected reference
   input wire logic conv_sample, // start pulse
   input wire logic over_in, // bench: input above reference
   output logic [RESULT_W-1:0] core_result, // raw code
   output logic core_overrange, // input above reference
   output logic core_single_ended // channel single-ended
);
   logic [CHAN_W-1:0] held_ch;
   logic [REF_W-1:0] held_ref;
   // code carries the selection held at sampling, so a late switch shows as a wrong code
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         held_ch <= '0;
         held_ref <= '0;
      end
      else if (conv_sample)
      begin
         held_ch <= active_channel;
         held_ref <= active_reference;
      end
   end
   assign core_result = {held_ref, 4'ha, held_ch};
   assign core_single_ended = held_ch < 4'hb;
   assign core_overrange = over_in && core_single_ended;
endmodule

/* File: testbench/acs_core_tb.sv */
// self-checking bench for the converter selection and sequencing block
`timescale 1ns/10ps
module acs_core_tb;
   import acs_pkg::*;
   logic clk_sys, rst_b, reg_wr, reg_rd, amp_trigger, auto_trigger_evt, cpu_halt_idle;
   logic [7:0] reg_addr, reg_wdata;
   logic [15:0] reg_rdata, q;
   logic [RESULT_W-1:0] core_result;
   logic core_overrange, core_single_ended, amp_input_short, conv_sample, conv_running;
   logic conv_enable, irq, over_in, ov;
   logic [CHAN_W-1:0] active_channel, ch;
   logic [REF_W-1:0] active_reference, rf;
   logic [31:0] r;
   integer seed, n_fail, checked, n;
   acs_core #(.PRESC_MAX_LOG(7)) u_acs_core (.clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .amp_trigger, .auto_trigger_evt, .cpu_halt_idle, .core_result,
      .core_overrange, .core_single_ended, .active_channel, .active_reference, .amp_input_short,
      .conv_sample, .conv_running, .conv_enable, .irq);
   acs_far_model u_acs_far_model (.clk_sys, .rst_b, .active_channel, .active_reference,
      .conv_sample, .over_in, .core_result, .core_overrange, .core_single_ended);
   function automatic logic [15:0] exp_res(input logic [3:0] c, input logic [1:0] f, input logic o);
      if (o && c < 4'hb)
         return {6'h00, FULL_SCALE};
      return {6'h00, f, 4'ha, c};
   endfunction
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
   endtask
   // bounded wait for a start pulse, or for the end of the running conversion
   task automatic wait_for(input logic fin);
      for (n = 0; n < 400; n++)
      begin
         @(posedge clk_sys);
         #1;
         if (fin ? conv_running === 1'b0 : conv_sample === 1'b1)
            break;
      end
      if (n == 400)
         n_fail++;
   endtask
   // model codes are exact, so no result after a reference switch is discarded
   task automatic pick;
      r = $random(seed);
      ch = r[3:0] % 4'hb;
      rf = r[7:6];
      wr(ADDR_SELECT, {rf, 2'b00, ch});
   endtask
   task automatic final_report;
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   initial
   begin
      #2000000;
      n_fail++;
      final_report;
   end
   initial
   begin
      {rst_b, reg_wr, reg_rd, amp_trigger, auto_trigger_evt, cpu_halt_idle, over_in} = '0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      seed = 32'ha080;
      n_fail = 0;
      checked = 0;
      repeat (6) @(posedge clk_sys);
      rst_b <= 1'b1;
      rd(8'hfc);
      cmp(q, 16'h0000);
      wr(ADDR_IRQ_MASK, 8'h01);
      pick;
      repeat (2) @(posedge clk_sys);
      #1 cmp({active_reference, active_channel}, {rf, ch});
      wr(ADDR_CONTROL_A, 8'hc8);
      wait_for(1'b0);
      // one converter cycle has passed since the start, so a new selection is legal here
      wr(ADDR_SELECT, {rf, 2'b00, ch ^ 4'h1});
      repeat (3) @(posedge clk_sys);
      #1 cmp({active_reference, active_channel}, {rf, ch});
      wait_for(1'b1);
      repeat (2) @(posedge clk_sys);
      #1 cmp({active_reference, active_channel}, {rf, ch ^ 4'h1});
      rd(ADDR_RESULT);
      cmp(q, exp_res(ch, rf, 1'b0));
      rd(ADDR_CONTROL_A);
      cmp({q[BIT_START], q[BIT_DONE]}, 16'h0001);
      cmp(irq, 1'b1);
      wr(ADDR_IRQ_MASK, 8'h00);
      @(posedge clk_sys);
      #1 cmp(irq, 1'b0);
      wr(ADDR_IRQ_MASK, 8'h01);
      @(posedge clk_sys);
      #1 cmp(irq, 1'b1);
      wr(ADDR_IRQ_STATUS, 8'h01);
      @(posedge clk_sys);
      #1 cmp(irq, 1'b0);
      repeat (4)
      begin
         pick;
         ov = r[9];
         over_in <= ov;
         wr(ADDR_CONTROL_A, 8'hd8);
         wait_for(1'b0);
         wait_for(1'b1);
         cmp(n >= CONV_NORMAL_CYC - 2 && n <= CONV_NORMAL_CYC + 2, 1'b1);
         rd(ADDR_RESULT);
         cmp(q, exp_res(ch, rf, ov));
      end
      over_in <= 1'b0;
      wr(ADDR_CONTROL_B, 8'h40);
      @(posedge clk_sys);
      #1 cmp(amp_input_short, 1'b1);
      wr(ADDR_CONTROL_B, 8'h81);
      repeat (20) @(posedge clk_sys);
      #1 cmp(conv_running, 1'b0);
      amp_trigger <= 1'b1;
      @(posedge clk_sys);
      amp_trigger <= 1'b0;
      wait_for(1'b0);
      cmp(n < 400, 1'b1);
      wait_for(1'b1);
      repeat (3) @(posedge clk_sys);
      #1 cmp(conv_running, 1'b0);
      rd(ADDR_CONTROL_A);
      cmp(q[BIT_START], 1'b0);
      wr(ADDR_CONTROL_B, 8'h01);
      pick;
      wr(ADDR_CONTROL_A, 8'hc0);
      wait_for(1'b0);
      wait_for(1'b0);
      wr(ADDR_SELECT, {rf, 2'b00, ch ^ 4'h2});
      wait_for(1'b0);
      rd(ADDR_RESULT);
      cmp(q, exp_res(ch, rf, 1'b0));
      wait_for(1'b0);
      rd(ADDR_RESULT);
      cmp(q, exp_res(ch ^ 4'h2, rf, 1'b0));
      wr(ADDR_CONTROL_A, 8'h00);
      wr(ADDR_CONTROL_B, 8'h00);
      wr(ADDR_CONTROL_A, 8'h98);
      wr(ADDR_IRQ_STATUS, 8'h07);
      cpu_halt_idle <= 1'b1;
      wait_for(1'b0);
      cmp(n < 400, 1'b1);
      cpu_halt_idle <= 1'b0;
      cmp(irq, 1'b0);
      wait_for(1'b1);
      cmp(n >= CONV_FIRST_CYC - 2 && n <= CONV_FIRST_CYC + 2, 1'b1);
      repeat (2) @(posedge clk_sys);
      #1 cmp(irq, 1'b1);
      cmp(conv_enable, 1'b1);
      // auto trigger: selection changed while auto is still off
      pick;
      wr(ADDR_CONTROL_A, 8'hb8);
      auto_trigger_evt <= 1'b1;
      wait_for(1'b0);
      cmp(n < 400, 1'b1);
      auto_trigger_evt <= 1'b0;
      wait_for(1'b1);
      rd(ADDR_RESULT);
      cmp(q, exp_res(ch, rf, 1'b0));
      final_report;
   end
endmodule
